// file: pkg/lbh_pkg.sv
// Package for the bridge configuration header block
package lbh_pkg;
	// Dword indices of the header (byte offset / 4)
	localparam logic [5:0]  IDX_IDENT    = 6'h00;
	localparam logic [5:0]  IDX_CMDSTAT  = 6'h01;
	localparam logic [5:0]  IDX_CLASSREV = 6'h02;
	// Byte offsets of the header registers
	localparam logic [7:0]  OFF_MAKER    = 8'h00;
	localparam logic [7:0]  OFF_PART     = 8'h02;
	localparam logic [7:0]  OFF_COMMAND  = 8'h04;
	localparam logic [7:0]  OFF_STATUS   = 8'h06;
	localparam logic [7:0]  OFF_STEPPING = 8'h08;
	localparam logic [7:0]  OFF_CLASS    = 8'h09;
	// Identification values, arbitrary neutral codes
	localparam logic [15:0] MAKER_VALUE  = 16'h1234;
	localparam logic [15:0] PART_VALUE   = 16'h5678;
	localparam logic [7:0]  STEP_VALUE   = 8'h01;
	localparam logic [23:0] CLASS_VALUE  = 24'h060100;
	// Command word: fixed ones in bits 3..0
	localparam logic [15:0] COMMAND_VALUE = 16'h000f;
	// Status field positions
	localparam int          ST_MABORT    = 13;
	localparam int          ST_TABORT    = 12;
	localparam logic [15:0] STATUS_FIXED = 16'h0200;
	// Byte enable lane carrying status bits 15:8 (upper byte of dword 1)
	localparam int          BE_STATUS_HI = 3;
	localparam int          BE_BIT_BASE  = 24;

	// Configuration access request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  index;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} lbh_req_type;

	// Abort events reported by the bridge master
	typedef struct packed {
		logic master_abort;
		logic target_abort;
	} lbh_evt_type;
endpackage

// file: rtl/lbh_config_header.sv
// Configuration header dwords 0..2 of the bus bridge function
//
// What this block does
// [R1] Command bit 3 always reads one
// [R2] Command bit 2 always reads one
// [R3] Command bits 1 and 0 read one
// [R4] Master-abort sets status bit 13; write-1 clears
// [R5] Target-abort sets status bit 12; write-1 clears
// [R6] Status bits 10:9 read fixed 01
// [R7] Class code reads 060100h, ignores writes
// [R8] Stepping byte read-only, fixed code
// [R9] Reserved bits read zero; writes discarded
`timescale 1ns/1ps
module lbh_config_header
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Configuration access
	input  wire lbh_pkg::lbh_req_type req,
	output logic                      rdata_valid,
	output logic [31:0]               rdata,
	// Abort events from the bridge master
	input  wire lbh_pkg::lbh_evt_type evt,
	// Status flags seen directly
	output logic                      master_abort_flag,
	output logic                      target_abort_flag
);

	logic        mabort;
	logic        tabort;
	logic        next_mabort;
	logic        next_tabort;
	logic        next_rdata_valid;
	logic [31:0] next_rdata;
	logic        clr_en;
	logic [15:0] status_now;

	// Status half sits above the command word in dword 1
	localparam int STATUS_LSB = $bits(lbh_pkg::COMMAND_VALUE);

	// Only a write hitting the status upper byte may clear flags
	assign clr_en = req.write && req.index == lbh_pkg::IDX_CMDSTAT
		&& req.byte_en[lbh_pkg::BE_STATUS_HI];

	// Sticky flags: a new event beats a same-cycle clear
	always_comb
	begin
		next_mabort = mabort;
		next_tabort = tabort;
		// Write-one clear, so writing zero to a flag bit never drops a flag
		if (clr_en && req.wdata[STATUS_LSB + lbh_pkg::ST_MABORT])
			next_mabort = 1'b0;
		if (clr_en && req.wdata[STATUS_LSB + lbh_pkg::ST_TABORT])
			next_tabort = 1'b0;
		// Set comes last so an abort in the clearing cycle is not lost
		if (evt.master_abort)
			next_mabort = 1'b1; // see [R4]
		if (evt.target_abort)
			next_tabort = 1'b1; // see [R5]
	end

	// Status word: fixed timing code, flags, the rest zero
	always_comb
	begin
		status_now = lbh_pkg::STATUS_FIXED; // see [R6] see [R9]
		status_now[lbh_pkg::ST_MABORT] = mabort;
		status_now[lbh_pkg::ST_TABORT] = tabort;
	end

	// Read mux; unmapped dwords and reserved bits read zero
	// A read in the cycle of a clear or an abort returns the old flags
	always_comb
	begin
		next_rdata_valid = req.read;
		next_rdata = 32'h0000_0000;
		if (req.read)
		begin
			unique case (req.index)
				lbh_pkg::IDX_IDENT:
					next_rdata = {lbh_pkg::PART_VALUE, lbh_pkg::MAKER_VALUE}; // see [R9]
				lbh_pkg::IDX_CMDSTAT:
					next_rdata = {status_now, lbh_pkg::COMMAND_VALUE}; // see [R1] see [R2] see [R3]
				lbh_pkg::IDX_CLASSREV:
					next_rdata = {lbh_pkg::CLASS_VALUE, lbh_pkg::STEP_VALUE}; // see [R7] see [R8]
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Register stage; all outputs come from here
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mabort      <= 1'b0;
			tabort      <= 1'b0;
			rdata_valid <= 1'b0;
			rdata       <= 32'h0000_0000;
		end
		else
		begin
			mabort      <= next_mabort;
			tabort      <= next_tabort;
			rdata_valid <= next_rdata_valid;
			rdata       <= next_rdata;
		end
	end

	// Flag pins come straight off the sticky flops
	assign master_abort_flag = mabort;
	assign target_abort_flag = tabort;

	// Master-abort event shows as set one cycle later
	property p_mabort_set;
		@(posedge clock) disable iff (!rst_n)
		evt.master_abort |=> mabort;
	endproperty
	a_mabort_set: assert property (p_mabort_set) else $error("master abort flag not set"); // see [R4]

	// Target-abort event shows as set one cycle later
	property p_tabort_set;
		@(posedge clock) disable iff (!rst_n)
		evt.target_abort |=> tabort;
	endproperty
	a_tabort_set: assert property (p_tabort_set) else $error("target abort flag not set"); // see [R5]

	// Flag falls only after a clearing write
	property p_mabort_clear;
		@(posedge clock) disable iff (!rst_n)
		$fell(mabort) |-> $past(clr_en) && $past(req.wdata[29]);
	endproperty
	a_mabort_clear: assert property (p_mabort_clear) else $error("master abort cleared wrongly"); // see [R4]

	// Same for the target-abort flag
	property p_tabort_clear;
		@(posedge clock) disable iff (!rst_n)
		$fell(tabort) |-> $past(clr_en) && $past(req.wdata[28]);
	endproperty
	a_tabort_clear: assert property (p_tabort_clear) else $error("target abort cleared wrongly"); // see [R5]

	// Command word low bits read as 000fh
	property p_command;
		@(posedge clock) disable iff (!rst_n)
		req.read && req.index == 6'h01 |=> rdata_valid && rdata[15:0] == 16'h000f;
	endproperty
	a_command: assert property (p_command) else $error("command word wrong"); // see [R1] see [R2] see [R3]

	// Status fixed bits and flags on read
	property p_status;
		@(posedge clock) disable iff (!rst_n)
		req.read && req.index == 6'h01 |=> rdata[27:16] == 12'h200 && rdata[31:30] == 2'b00
			&& rdata[29] == $past(mabort) && rdata[28] == $past(tabort);
	endproperty
	a_status: assert property (p_status) else $error("status word wrong"); // see [R6] see [R9]

	// Class code and stepping constant
	property p_class;
		@(posedge clock) disable iff (!rst_n)
		req.read && req.index == 6'h02 |=> rdata == 32'h0601_0001;
	endproperty
	a_class: assert property (p_class) else $error("class or stepping wrong"); // see [R7] see [R8]

	// Unmapped dwords read zero
	property p_unmapped;
		@(posedge clock) disable iff (!rst_n)
		req.read && req.index > 6'h02 |=> rdata_valid && rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // see [R9]

	// Reset leaves both flags clear and no answer pending
	property p_reset_state;
		@(posedge clock)
		!rst_n |=> !mabort && !tabort && !rdata_valid && rdata == 32'h0000_0000;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset"); // see [R4] see [R5]

	// Master-abort flag is sticky: no event and no clear, no change
	property p_mabort_hold;
		@(posedge clock) disable iff (!rst_n)
		!evt.master_abort && !(clr_en && req.wdata[29]) |=> mabort == $past(mabort);
	endproperty
	a_mabort_hold: assert property (p_mabort_hold) else $error("master abort flag moved"); // see [R4]

	// Target-abort flag is sticky the same way
	property p_tabort_hold;
		@(posedge clock) disable iff (!rst_n)
		!evt.target_abort && !(clr_en && req.wdata[28]) |=> tabort == $past(tabort);
	endproperty
	a_tabort_hold: assert property (p_tabort_hold) else $error("target abort flag moved"); // see [R5]

	// A clear meeting a master-abort in one cycle leaves the flag set
	property p_mabort_set_wins;
		@(posedge clock) disable iff (!rst_n)
		evt.master_abort && clr_en && req.wdata[29] |=> mabort;
	endproperty
	a_mabort_set_wins: assert property (p_mabort_set_wins) else $error("master abort lost to clear"); // see [R4]

	// A clear meeting a target-abort in one cycle leaves the flag set
	property p_tabort_set_wins;
		@(posedge clock) disable iff (!rst_n)
		evt.target_abort && clr_en && req.wdata[28] |=> tabort;
	endproperty
	a_tabort_set_wins: assert property (p_tabort_set_wins) else $error("target abort lost to clear"); // see [R5]

	// Writes and idle cycles give no answer
	property p_no_answer;
		@(posedge clock) disable iff (!rst_n)
		!req.read |=> !rdata_valid;
	endproperty
	a_no_answer: assert property (p_no_answer) else $error("answer without a read"); // see [R9]

	// Data lines rest at zero between answers
	property p_rdata_idle;
		@(posedge clock) disable iff (!rst_n)
		!rdata_valid |-> rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero while idle"); // see [R9]

	// Identification words read back unchanged after any write
	property p_ident;
		@(posedge clock) disable iff (!rst_n)
		req.read && req.index == 6'h00 |=> rdata_valid && rdata == {lbh_pkg::PART_VALUE, lbh_pkg::MAKER_VALUE};
	endproperty
	a_ident: assert property (p_ident) else $error("identification word wrong"); // see [R9]

endmodule

// file: verification/lbh_abort_src.sv
// Bridge master stand-in that reports abort terminations
`timescale 1ns/1ps
module lbh_abort_src
(
	// Clock
	input  wire logic            clock,
	// Commands from the bench
	input  wire logic            fire_m,
	input  wire logic            fire_t,
	// Abort events
	output lbh_pkg::lbh_evt_type evt
);
	// One event cycle per command, launched after the edge
	always @(posedge clock)
	begin
		evt.master_abort <= fire_m;
		evt.target_abort <= fire_t;
	end
endmodule

// file: verification/lbh_config_header_bench.sv
// Self-checking bench for the configuration header
`timescale 1ns/1ps
module lbh_config_header_bench;
	logic                 clock = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 fire_m = 1'b0;
	logic                 fire_t = 1'b0;
	lbh_pkg::lbh_req_type req = '0;
	lbh_pkg::lbh_evt_type evt;
	logic                 rdata_valid;
	logic                 master_abort_flag;
	logic                 target_abort_flag;
	logic [31:0]          rdata;
	logic [31:0]          rnd;
	logic [33:0]          exp_q[$];
	logic [33:0]          note;
	logic                 exp_m = 1'b0;
	logic                 exp_t = 1'b0;
	int                   error_cnt = 0;
	int                   cmp_count = 0;
	localparam logic [31:0] ID0 = {lbh_pkg::PART_VALUE, lbh_pkg::MAKER_VALUE};
	localparam logic [31:0] CS0 = 32'h0200_000f;
	localparam logic [31:0] CR0 = {24'h060100, lbh_pkg::STEP_VALUE};

	always #50 clock = ~clock;

	lbh_config_header DUT (.clock(clock), .rst_n(rst_n), .req(req), .rdata_valid(rdata_valid), .rdata(rdata),
		.evt(evt), .master_abort_flag(master_abort_flag), .target_abort_flag(target_abort_flag));
	lbh_abort_src PEER (.clock(clock), .fire_m(fire_m), .fire_t(fire_t), .evt(evt));

	task chk(input logic [31:0] e, input logic [31:0] a);
		cmp_count++;
		if (a !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, e, a);
		end
	endtask

	// Flag pins, master then target
	task chk_flags(input logic [1:0] e, input logic [1:0] a);
		cmp_count++;
		if (a !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, e, a);
		end
	endtask

	// One request per edge; a read notes its expected answer
	task acc(input logic r, input logic w, input logic [5:0] i, input logic [3:0] b, input logic [31:0] d, e);
		@(posedge clock);
		req <= '{r, w, i, b, d};
		// Writing 1 to status bits 13/12 through the top lane clears them
		if (w && i == lbh_pkg::IDX_CMDSTAT && b[lbh_pkg::BE_STATUS_HI])
		begin
			if (d[29])
				exp_m = 1'b0;
			if (d[28])
				exp_t = 1'b0;
		end
		if (r)
			exp_q.push_back({exp_m, exp_t, e});
	endtask

	// Idle the port while an abort travels through the peer
	task ev(input logic m, input logic t);
		@(posedge clock);
		req <= '0;
		fire_m <= m;
		fire_t <= t;
		@(posedge clock);
		fire_m <= 1'b0;
		fire_t <= 1'b0;
		@(posedge clock);
		exp_m = exp_m | m;
		exp_t = exp_t | t;
	endtask

	// Abort and clearing write taken at the same edge; the abort must win
	task clash(input logic m, input logic t);
		@(posedge clock);
		req <= '0;
		fire_m <= m;
		fire_t <= t;
		@(posedge clock);
		fire_m <= 1'b0;
		fire_t <= 1'b0;
		req <= '{1'b0, 1'b1, lbh_pkg::IDX_CMDSTAT, 4'h8, {2'b00, m, t, 28'h0}};
		exp_m = exp_m | m;
		exp_t = exp_t | t;
	endtask

	// Mid-run reset, held three edges so the flags settle before release
	task reboot;
		@(posedge clock);
		req <= '0;
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		exp_m = 1'b0;
		exp_t = 1'b0;
	endtask

	task close_out;
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Falling edge avoids racing the registered answer
	always @(negedge clock)
		if (rdata_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				error_cnt++;
				$display("[ERR] %0t exp %h got %h", $time, 32'h0, rdata);
			end
			else
			begin
				note = exp_q.pop_front();
				chk(note[31:0], rdata);
				chk_flags(note[33:32], {master_abort_flag, target_abort_flag});
			end
		end

	initial
	begin
		void'($urandom(32'h3dbe));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		acc(1, 0, 6'h0, 4'h0, 0, ID0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0);
		acc(1, 0, 6'h2, 4'h0, 0, CR0);
		acc(1, 0, 6'h3, 4'h0, 0, 0);
		// Random writes everywhere except the two clear bits
		for (int k = 0; k < 3; k++)
		begin
			rnd = $urandom() & 32'hcfff_ffff;
			acc(0, 1, k[5:0], 4'hf, rnd, 0);
			acc(1, 0, k[5:0], 4'h0, 0, (k == 0) ? ID0 : (k == 1) ? CS0 : CR0);
		end
		ev(1, 0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0 | 32'h2000_0000);
		acc(0, 1, 6'h1, 4'h7, 32'h2000_0000, 0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0 | 32'h2000_0000);
		acc(0, 1, 6'h1, 4'h8, 32'h1000_0000, 0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0 | 32'h2000_0000);
		acc(0, 1, 6'h1, 4'h8, 32'h2000_0000, 0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0);
		ev(0, 1);
		acc(1, 0, 6'h1, 4'h0, 0, CS0 | 32'h1000_0000);
		acc(0, 1, 6'h1, 4'h8, 32'h1000_0000, 0);
		acc(1, 0, 6'h1, 4'h0, 0, CS0);
		clash(1, 1);
		acc(1, 0, 6'h1, 4'h0, 0, CS0 | 32'h3000_0000);
		reboot();
		acc(1, 0, 6'h1, 4'h0, 0, CS0);
		@(posedge clock);
		req <= '0;
		for (int n = 0; n < 10 && exp_q.size() > 0; n++)
			@(posedge clock);
		if (exp_q.size() > 0)
		begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, 32'h0, exp_q.size());
		end
		close_out();
	end
endmodule
